/* option_pkg.sv */
// Constants, field layouts and carrier types for the option reference and
// monitor logic. Assumes one clock domain and a plain register port.
package option_pkg;

  localparam int          DATA_W        = 16;
  localparam int          ADDR_W        = 4;
  localparam int          DIG_W         = 17;
  localparam int          AIN_W         = 14;
  localparam int          PCT_W         = 14;
  localparam int          DAC_W         = 12;
  localparam int          ITEM_N        = 39;

  localparam logic [3:0]  A_ANALOG_MODE = 4'h0;
  localparam logic [3:0]  A_DIG_FORMAT  = 4'h1;
  localparam logic [3:0]  A_DISP_SCALE  = 4'h2;
  localparam logic [3:0]  A_REF_SOURCE  = 4'h3;
  localparam logic [3:0]  A_MON1_ITEM   = 4'h4;
  localparam logic [3:0]  A_MON1_GAIN   = 4'h5;
  localparam logic [3:0]  A_MON1_BIAS   = 4'h6;
  localparam logic [3:0]  A_MON2_ITEM   = 4'h7;
  localparam logic [3:0]  A_MON2_GAIN   = 4'h8;
  localparam logic [3:0]  A_MON2_BIAS   = 4'h9;
  localparam logic [3:0]  A_OUT_LEVEL   = 4'ha;
  localparam logic [3:0]  A_STATUS      = 4'hb;
  localparam logic [3:0]  A_FREQ_REF    = 4'hc;

  localparam int          ST_REFUSED    = 0;
  localparam int          ST_RUNNING    = 1;
  localparam int          ST_OPTINV_OFF = 2;
  localparam int          ST_SPEC_BAD   = 3;

  localparam logic        MODE_RST      = 1'h0;
  localparam logic [2:0]  FMT_RST       = 3'h0;
  localparam logic [15:0] DISP_RST      = 16'h0000;
  localparam logic [2:0]  SRC_RST       = 3'h1;
  localparam logic [5:0]  ITEM1_RST     = 6'h02;
  localparam logic [5:0]  ITEM2_RST     = 6'h03;
  localparam logic [7:0]  GAIN1_RST     = 8'h64;
  localparam logic [7:0]  GAIN2_RST     = 8'h32;
  localparam logic [7:0]  BIAS_RST      = 8'h00;
  localparam logic        LEVEL_RST     = 1'h0;

  localparam logic [2:0]  FMT_BCD_1PCT  = 3'h0;
  localparam logic [2:0]  FMT_BCD_01PCT = 3'h1;
  localparam logic [2:0]  FMT_BCD_001PCT = 3'h2;
  localparam logic [2:0]  FMT_BCD_1HZ   = 3'h3;
  localparam logic [2:0]  FMT_BCD_01HZ  = 3'h4;
  localparam logic [2:0]  FMT_BCD_001HZ = 3'h5;
  localparam logic [2:0]  FMT_BCD_SPEC  = 3'h6;
  localparam logic [2:0]  FMT_BINARY    = 3'h7;

  localparam logic [2:0]  CARD_NONE     = 3'h0;
  localparam logic [2:0]  CARD_AN2      = 3'h1;
  localparam logic [2:0]  CARD_AN3      = 3'h2;
  localparam logic [2:0]  CARD_DIG8     = 3'h3;
  localparam logic [2:0]  CARD_DIG16    = 3'h4;

  localparam logic [2:0]  SRC_TERMINAL  = 3'h1;
  localparam logic [2:0]  SRC_OPTION    = 3'h3;
  localparam logic [15:0] DISP_BCD_MIN  = 16'h0002;

  localparam int          PCT_FULL      = 10000;
  localparam int          GAIN_MAX      = 250;
  localparam int          GAIN_UNIT     = 100;
  localparam int          BIAS_MAX      = 100;
  localparam int          BIAS_STEP     = 10;
  localparam int          ITEM_MAX      = 38;
  localparam int          BIN8_FULL     = 32'h0000_00ff;
  localparam int          BIN12_FULL    = 32'h0000_0fff;
  localparam int          BIN16_FULL    = 32'h0000_7530;
  localparam int          DAC12_FULL    = 32'h0000_0fff;
  localparam int          DAC8_FULL     = 32'h0000_00ff;
  localparam int          BCD_DIGIT_MAX = 9;
  localparam logic [38:0] ITEM_BARRED   = 39'h0c_f200_6c11;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  typedef struct packed {
    logic [DAC_W-1:0] ch1_code;
    logic             ch1_bipolar;
    logic [DAC_W-1:0] ch2_code;
    logic             ch2_bipolar;
  } mon_out_t;

  typedef enum logic [1:0] {
    PH_IDLE   = 2'b01,
    PH_UPDATE = 2'b10
  } ref_phase_t;

endpackage : option_pkg

/* bcd_ref_decode.sv */
// Combinational decoder that turns the parallel reference word into an
// integer, in ordinary BCD or in the five-digit special layout.
// Assumes the caller holds the word stable while the result is used.
`timescale 1ns/1ps
`default_nettype none
module bcd_ref_decode
  import option_pkg::*;
(
  input  wire logic [DIG_W-1:0] raw,
  input  wire logic             special,
  input  wire logic             card8,
  output logic      [15:0]      value
);

  // Out-of-range nibbles saturate at nine rather than wrapping.
  function automatic int digit(input logic [3:0] nib);
    digit = (int'(nib) > BCD_DIGIT_MAX) ? BCD_DIGIT_MAX : int'(nib);
  endfunction : digit

  int acc;

  always_comb begin
    acc = 0;
    if (special) begin
      acc = int'(raw[16:15]) * 10000 + digit(raw[14:11]) * 1000
          + digit(raw[10:7]) * 100 + digit(raw[6:3]) * 10
          + digit({raw[2:0], 1'b0});
    end else if (card8) begin
      acc = int'(raw[8]) * 100 + digit(raw[7:4]) * 10
          + digit(raw[3:0]);
    end else begin
      acc = int'(raw[16]) * 10000 + digit(raw[15:12]) * 1000
          + digit(raw[11:8]) * 100 + digit(raw[7:4]) * 10
          + digit(raw[3:0]);
    end
    value = acc[15:0];
  end

endmodule : bcd_ref_decode
`default_nettype wire

/* option_ref_monitor.sv */
// Option card reference and monitor logic: analog and digital frequency
// reference paths, two analog monitor channels and their settings.
// Assumes card identity and running state are synchronous inputs.
`timescale 1ns/1ps
`default_nettype none
module option_ref_monitor
  import option_pkg::*;
#(
  parameter int          FMAX_CENTI_HZ = 6000,
  parameter int          AIN_FULL      = 8191,
  parameter logic [38:0] UNIPOLAR_ONLY = 39'h00_0000_0000
)(
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  input  wire reg_req_t                      reg_req,
  output logic      [DATA_W-1:0]             reg_rdata,
  input  wire logic                          drive_running,
  input  wire logic                          ctrl_tick,
  input  wire logic [2:0]                    ref_card_type,
  input  wire logic                          dig16_bits16,
  input  wire logic                          mon_card_12bit,
  input  wire logic [DIG_W-1:0]              dig_in,
  input  wire logic [2:0][AIN_W-1:0]         ain,
  input  wire logic [ITEM_N-1:0][15:0]       mon_item_values,
  input  wire logic                          opt_inv_sel_in,
  output logic                               opt_inv_sel_out,
  output logic      [PCT_W-1:0]              freq_ref,
  output logic                               freq_ref_valid,
  output logic      [2:0][PCT_W-1:0]         ch_pct,
  output var mon_out_t                       mon_out
);

  typedef struct packed {
    logic                    analog_mode;
    logic [2:0]              fmt;
    logic [15:0]             disp;
    logic [2:0]              src;
    logic [1:0][5:0]         item;
    logic [1:0][7:0]         gain;
    logic [1:0][7:0]         bias;
    logic                    level;
    logic                    refused;
    logic                    spec_bad;
    ref_phase_t              phase;
    logic [DIG_W-1:0]        sample;
    logic [2:0][AIN_W-1:0]   ain_sample;
    logic [PCT_W-1:0]        freq_ref;
    logic                    ref_valid;
    logic [2:0][PCT_W-1:0]   ch_pct;
    logic                    opt_inv;
    mon_out_t                mon;
    logic [DATA_W-1:0]       rdata;
  } state_t;

  state_t state_ff;
  state_t nxt_state;

  function automatic logic [PCT_W-1:0] clamp_pct(input int v);
    int c;
    c = (v < 0) ? 0 : ((v > PCT_FULL) ? PCT_FULL : v);
    clamp_pct = c[PCT_W-1:0];
  endfunction : clamp_pct

  function automatic logic item_ok(input logic [DATA_W-1:0] v);
    item_ok = (int'(v) <= ITEM_MAX) && !ITEM_BARRED[v[5:0]];
  endfunction : item_ok

  function automatic logic bias_ok(input logic [DATA_W-1:0] v);
    int s;
    s = int'($signed(v));
    bias_ok = (s >= -BIAS_MAX) && (s <= BIAS_MAX);
  endfunction : bias_ok

  // Output code for one monitor channel. Bias is kept in tenths of a
  // percent but acts only in whole percent steps, so 0.5% does nothing.
  function automatic logic [DAC_W-1:0] mon_code(
    input logic [15:0] item_val,
    input logic [7:0]  gain,
    input logic [7:0]  bias,
    input logic        bipolar,
    input logic        card12
  );
    int v;
    int code;
    v = int'($signed(item_val)) * int'(gain) / GAIN_UNIT;
    v = v + (int'($signed(bias)) / BIAS_STEP) * (PCT_FULL / 100);
    if (bipolar) begin
      v = (v < -PCT_FULL) ? -PCT_FULL : ((v > PCT_FULL) ? PCT_FULL : v);
      code = (v + PCT_FULL) * DAC12_FULL / (2 * PCT_FULL);
    end else begin
      v = (v < 0) ? 0 : ((v > PCT_FULL) ? PCT_FULL : v);
      code = v * (card12 ? DAC12_FULL : DAC8_FULL) / PCT_FULL;
    end
    mon_code = code[DAC_W-1:0];
  endfunction : mon_code

  logic        card8;
  logic        card16;
  logic        card_an3;
  logic        spec_mode;
  logic [15:0] bcd_val;

  assign card8     = (ref_card_type == CARD_DIG8);
  assign card16    = (ref_card_type == CARD_DIG16);
  assign card_an3  = (ref_card_type == CARD_AN3);
  // Special layout only on the wide card and only at low display scaling.
  assign spec_mode = (state_ff.fmt == FMT_BCD_SPEC) && card16
                   && (state_ff.disp < DISP_BCD_MIN);

  bcd_ref_decode u_bcd (
    .raw     (state_ff.sample),
    .special (spec_mode),
    .card8   (card8),
    .value   (bcd_val)
  );

  int          dig_pct;
  int          hz_val;
  int          bin_full;
  int          an_sum;
  logic        use_hz;
  logic        ref_active;
  logic        is_digital;
  logic        refuse_set;
  logic        refuse_clr;
  logic [1:0]  bip;
  logic [2:0][PCT_W-1:0] an_pct;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.ref_valid = 1'b0;
    nxt_state.rdata = '0;
    refuse_set = 1'b0;
    refuse_clr = 1'b0;
    dig_pct = 0;
    hz_val = 0;
    use_hz = 1'b0;
    bin_full = BIN8_FULL;
    an_sum = 0;
    is_digital = card8 || card16;
    bip = 2'b00;
    an_pct = '0;

    if (reg_req.wr) begin
      case (reg_req.addr)
        A_ANALOG_MODE: begin
          if (drive_running) refuse_set = 1'b1;
          else nxt_state.analog_mode = reg_req.wdata[0];
        end
        A_DIG_FORMAT: begin
          if (drive_running) refuse_set = 1'b1;
          else nxt_state.fmt = reg_req.wdata[2:0];
        end
        A_DISP_SCALE: nxt_state.disp = reg_req.wdata;
        A_REF_SOURCE: nxt_state.src = reg_req.wdata[2:0];
        A_MON1_ITEM: begin
          if (drive_running || !item_ok(reg_req.wdata)) begin
            refuse_set = 1'b1;
          end else begin
            nxt_state.item[0] = reg_req.wdata[5:0];
          end
        end
        A_MON2_ITEM: begin
          if (drive_running || !item_ok(reg_req.wdata)) begin
            refuse_set = 1'b1;
          end else begin
            nxt_state.item[1] = reg_req.wdata[5:0];
          end
        end
        A_MON1_GAIN: begin
          if (int'(reg_req.wdata) > GAIN_MAX) refuse_set = 1'b1;
          else nxt_state.gain[0] = reg_req.wdata[7:0];
        end
        A_MON2_GAIN: begin
          if (int'(reg_req.wdata) > GAIN_MAX) refuse_set = 1'b1;
          else nxt_state.gain[1] = reg_req.wdata[7:0];
        end
        A_MON1_BIAS: begin
          if (!bias_ok(reg_req.wdata)) refuse_set = 1'b1;
          else nxt_state.bias[0] = reg_req.wdata[7:0];
        end
        A_MON2_BIAS: begin
          if (!bias_ok(reg_req.wdata)) refuse_set = 1'b1;
          else nxt_state.bias[1] = reg_req.wdata[7:0];
        end
        A_OUT_LEVEL: nxt_state.level = reg_req.wdata[0];
        A_STATUS: refuse_clr = reg_req.wdata[ST_REFUSED];
        default: ;
      endcase
    end
    // A refusal in the same cycle as a clear keeps the flag set.
    nxt_state.refused = (state_ff.refused & ~refuse_clr) | refuse_set;

    if (reg_req.rd) begin
      case (reg_req.addr)
        A_ANALOG_MODE: nxt_state.rdata = {15'h0000, state_ff.analog_mode};
        A_DIG_FORMAT:  nxt_state.rdata = {13'h0000, state_ff.fmt};
        A_DISP_SCALE:  nxt_state.rdata = state_ff.disp;
        A_REF_SOURCE:  nxt_state.rdata = {13'h0000, state_ff.src};
        A_MON1_ITEM:   nxt_state.rdata = {10'h000, state_ff.item[0]};
        A_MON1_GAIN:   nxt_state.rdata = {8'h00, state_ff.gain[0]};
        A_MON1_BIAS:   nxt_state.rdata = {{8{state_ff.bias[0][7]}},
                                          state_ff.bias[0]};
        A_MON2_ITEM:   nxt_state.rdata = {10'h000, state_ff.item[1]};
        A_MON2_GAIN:   nxt_state.rdata = {8'h00, state_ff.gain[1]};
        A_MON2_BIAS:   nxt_state.rdata = {{8{state_ff.bias[1][7]}},
                                          state_ff.bias[1]};
        A_OUT_LEVEL:   nxt_state.rdata = {15'h0000, state_ff.level};
        A_STATUS: begin
          nxt_state.rdata[ST_REFUSED]    = state_ff.refused;
          nxt_state.rdata[ST_RUNNING]    = drive_running;
          nxt_state.rdata[ST_OPTINV_OFF] = card_an3;
          nxt_state.rdata[ST_SPEC_BAD]   = state_ff.spec_bad;
        end
        A_FREQ_REF:    nxt_state.rdata = {2'b00, state_ff.freq_ref};
        default:       nxt_state.rdata = '0;
      endcase
    end

    // Digital path: scale the decoded value, or the raw sample in binary, to hundredths of a percent.
    case (state_ff.fmt)
      FMT_BCD_1PCT:   dig_pct = int'(bcd_val) * 100;
      FMT_BCD_01PCT:  dig_pct = int'(bcd_val) * 10;
      FMT_BCD_001PCT: dig_pct = int'(bcd_val);
      FMT_BCD_1HZ: begin
        hz_val = int'(bcd_val) * 100;
        use_hz = 1'b1;
      end
      FMT_BCD_01HZ: begin
        hz_val = int'(bcd_val) * 10;
        use_hz = 1'b1;
      end
      FMT_BCD_001HZ: begin
        hz_val = int'(bcd_val);
        use_hz = 1'b1;
      end
      FMT_BCD_SPEC: begin
        hz_val = card16 ? int'(bcd_val) : 0;
        use_hz = 1'b1;
      end
      FMT_BINARY: begin
        if (card16) bin_full = dig16_bits16 ? BIN16_FULL : BIN12_FULL;
        else bin_full = BIN8_FULL;
        if (card8) dig_pct = int'(state_ff.sample[7:0]) * PCT_FULL / bin_full;
        else if (dig16_bits16)
          dig_pct = int'(state_ff.sample[15:0]) * PCT_FULL / bin_full;
        else dig_pct = int'(state_ff.sample[11:0]) * PCT_FULL / bin_full;
      end
      default: dig_pct = 0;
    endcase
    // Saturate before scaling so a large BCD word cannot overflow.
    if (use_hz && hz_val >= FMAX_CENTI_HZ) dig_pct = PCT_FULL;
    else if (use_hz) dig_pct = hz_val * PCT_FULL / FMAX_CENTI_HZ;

    for (int i = 0; i < 3; i++) begin
      an_pct[i] = clamp_pct(int'($signed(state_ff.ain_sample[i]))
                            * PCT_FULL / AIN_FULL);
      an_sum = an_sum + int'(an_pct[i]);
    end

    // Summed analog reaches the reference through the terminal source;
    // everything else from a card expects the option source.
    if (card_an3 && state_ff.analog_mode)
      ref_active = (state_ff.src == SRC_TERMINAL);
    else
      ref_active = (state_ff.src == SRC_OPTION)
                 && (ref_card_type != CARD_NONE);

    case (state_ff.phase)
      PH_IDLE: begin
        if (ctrl_tick) begin
          nxt_state.sample = dig_in;
          nxt_state.ain_sample = ain;
          nxt_state.phase = PH_UPDATE;
        end
      end
      PH_UPDATE: begin
        nxt_state.ch_pct = an_pct;
        nxt_state.spec_bad = (state_ff.fmt == FMT_BCD_SPEC) && !card16;
        if (ref_active) begin
          if (is_digital) nxt_state.freq_ref = clamp_pct(dig_pct);
          else if (card_an3 && state_ff.analog_mode)
            nxt_state.freq_ref = clamp_pct(an_sum);
          else nxt_state.freq_ref = an_pct[0];
          nxt_state.ref_valid = 1'b1;
        end
        nxt_state.phase = PH_IDLE;
      end
      default: nxt_state.phase = PH_IDLE;
    endcase

    nxt_state.opt_inv = opt_inv_sel_in && !card_an3;

    for (int c = 0; c < 2; c++) begin
      bip[c] = state_ff.level && mon_card_12bit
             && !UNIPOLAR_ONLY[state_ff.item[c]];
    end
    nxt_state.mon.ch1_bipolar = bip[0];
    nxt_state.mon.ch2_bipolar = bip[1];
    nxt_state.mon.ch1_code = mon_code(mon_item_values[state_ff.item[0]],
                                      state_ff.gain[0], state_ff.bias[0],
                                      bip[0], mon_card_12bit);
    nxt_state.mon.ch2_code = mon_code(mon_item_values[state_ff.item[1]],
                                      state_ff.gain[1], state_ff.bias[1],
                                      bip[1], mon_card_12bit);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff             <= '0;
      state_ff.analog_mode <= MODE_RST;
      state_ff.fmt         <= FMT_RST;
      state_ff.disp        <= DISP_RST;
      state_ff.src         <= SRC_RST;
      state_ff.item[0]     <= ITEM1_RST;
      state_ff.item[1]     <= ITEM2_RST;
      state_ff.gain[0]     <= GAIN1_RST;
      state_ff.gain[1]     <= GAIN2_RST;
      state_ff.bias[0]     <= BIAS_RST;
      state_ff.bias[1]     <= BIAS_RST;
      state_ff.level       <= LEVEL_RST;
      state_ff.phase       <= PH_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign reg_rdata       = state_ff.rdata;
  assign opt_inv_sel_out = state_ff.opt_inv;
  assign freq_ref        = state_ff.freq_ref;
  assign freq_ref_valid  = state_ff.ref_valid;
  assign ch_pct          = state_ff.ch_pct;
  assign mon_out         = state_ff.mon;

endmodule : option_ref_monitor
`default_nettype wire

/* option_chk.sv */
// Checker for the option reference and monitor logic, bound to its top.
// Assumes one clock domain and the register map of the package.
`timescale 1ns/1ps
`default_nettype none
module option_chk
  import option_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire reg_req_t          reg_req,
  input  wire logic [DATA_W-1:0] reg_rdata,
  input  wire logic              drive_running,
  input  wire logic              ctrl_tick,
  input  wire logic [2:0]        ref_card_type,
  input  wire logic              mon_card_12bit,
  input  wire logic              opt_inv_sel_out,
  input  wire logic [PCT_W-1:0]  freq_ref,
  input  wire logic              freq_ref_valid,
  input  wire mon_out_t          mon_out
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_wr_run(logic [3:0] a);
    reg_req.wr && reg_req.addr == a && drive_running;
  endsequence
  sequence s_rd(logic [3:0] a);
    reg_req.rd && reg_req.addr == a;
  endsequence

  property p_mode_lock;
    s_wr_run(A_ANALOG_MODE) ##1 s_rd(A_STATUS) |=> reg_rdata[ST_REFUSED];
  endproperty
  a_mode_lock: assert property (p_mode_lock)
    else $error("mode write while running was not flagged");
  property p_item_lock;
    s_wr_run(A_MON1_ITEM) ##1 s_rd(A_STATUS) |=> reg_rdata[ST_REFUSED];
  endproperty
  a_item_lock: assert property (p_item_lock)
    else $error("item write while running was not flagged");
  property p_gain_live;
    (reg_req.wr && reg_req.addr == A_MON1_GAIN && reg_req.wdata <= 16'h00fa)
      ##1 s_rd(A_MON1_GAIN) |=> reg_rdata == $past(reg_req.wdata, 2);
  endproperty
  a_gain_live: assert property (p_gain_live)
    else $error("legal gain write did not take effect");
  property p_running;
    s_rd(A_STATUS) |=> reg_rdata[ST_RUNNING] == $past(drive_running);
  endproperty
  a_running: assert property (p_running)
    else $error("status running bit wrong");
  property p_valid_cause;
    freq_ref_valid |-> $past(ctrl_tick, 2);
  endproperty
  a_valid_cause: assert property (p_valid_cause)
    else $error("reference update without a tick two cycles before");
  property p_ref_hold;
    !freq_ref_valid |-> $stable(freq_ref);
  endproperty
  a_ref_hold: assert property (p_ref_hold)
    else $error("reference changed without an update pulse");
  property p_opt_off;
    ref_card_type == CARD_AN3 |=> !opt_inv_sel_out;
  endproperty
  a_opt_off: assert property (p_opt_off)
    else $error("option select passed with three-input card");
  property p_mon8;
    !mon_card_12bit |=> !mon_out.ch1_bipolar && !mon_out.ch2_bipolar
      && mon_out.ch1_code <= 12'h0ff && mon_out.ch2_code <= 12'h0ff;
  endproperty
  a_mon8: assert property (p_mon8)
    else $error("8-bit monitor card output out of unipolar range");
endmodule : option_chk

bind option_ref_monitor option_chk i_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .reg_req(reg_req),
  .reg_rdata(reg_rdata), .drive_running(drive_running),
  .ctrl_tick(ctrl_tick), .ref_card_type(ref_card_type),
  .mon_card_12bit(mon_card_12bit), .opt_inv_sel_out(opt_inv_sel_out),
  .freq_ref(freq_ref), .freq_ref_valid(freq_ref_valid), .mon_out(mon_out)
);
`default_nettype wire

/* card_model.sv */
// Model of the plug-in reference and monitor cards at the block's far side.
// Assumes the bench sets the wanted levels; the card latches them each clock.
`timescale 1ns/1ps
`default_nettype none
module card_model
  import option_pkg::*;
(
  input  wire logic                    sys_clk,
  input  wire logic [DIG_W-1:0]        word_set,
  input  wire logic [2:0][AIN_W-1:0]   ain_set,
  input  wire logic [15:0]             item_set,
  output logic      [DIG_W-1:0]        dig_in,
  output logic      [2:0][AIN_W-1:0]   ain,
  output logic      [ITEM_N-1:0][15:0] mon_item_values
);
  // Lines settle one clock late, so the block never sees a same-edge change.
  always_ff @(posedge sys_clk) begin
    dig_in <= word_set;
    ain <= ain_set;
    for (int i = 0; i < ITEM_N; i++) mon_item_values[i] <= item_set;
  end
endmodule : card_model
`default_nettype wire

/* option_ref_monitor_tb.sv */
// Self-checking bench for the option reference and monitor logic.
// Assumes the card model on the far side and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module option_ref_monitor_tb
  import option_pkg::*;
;
  logic sys_clk, rst_n, run, tick, b16, m12, oin, oout, fvalid;
  logic [2:0]              ctype;
  reg_req_t                req;
  logic [15:0]             rdata, itemv;
  logic [PCT_W-1:0]        fref;
  logic [2:0][PCT_W-1:0]   chp;
  mon_out_t                mon;
  logic [DIG_W-1:0]        word, dig;
  logic [2:0][AIN_W-1:0]   ainv, ain;
  logic [ITEM_N-1:0][15:0] items;
  int mismatches, checks_done;

  option_ref_monitor #(.UNIPOLAR_ONLY(39'h00_0000_0008)) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n),
    .reg_req(req), .reg_rdata(rdata), .drive_running(run), .ctrl_tick(tick),
    .ref_card_type(ctype), .dig16_bits16(b16), .mon_card_12bit(m12),
    .dig_in(dig), .ain(ain), .mon_item_values(items),
    .opt_inv_sel_in(oin), .opt_inv_sel_out(oout), .freq_ref(fref),
    .freq_ref_valid(fvalid), .ch_pct(chp), .mon_out(mon));
  card_model i_card (.sys_clk(sys_clk), .word_set(word), .ain_set(ainv),
    .item_set(itemv), .dig_in(dig), .ain(ain), .mon_item_values(items));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  task automatic stop_test;
    if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stop_test

  task automatic chk(input string n, input logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk) req <= {a, d, 2'b10};
    @(posedge sys_clk) req <= '0;
  endtask : wr

  // An optional write runs straight into the read, with no idle cycle.
  task automatic xfer(input logic w, input logic [3:0] a,
                      input logic [15:0] d, input logic [3:0] ra,
                      input logic [15:0] e, m);
    if (w) @(posedge sys_clk) req <= {a, d, 2'b10};
    @(posedge sys_clk) req <= {ra, 16'h0000, 2'b01};
    @(posedge sys_clk) req <= '0;
    #1 chk("reg_rdata", e & m, rdata & m);
  endtask : xfer

  task automatic tick_chk(input logic ev, input logic [16:0] w,
                          input logic [15:0] e);
    @(posedge sys_clk) word <= w;
    @(posedge sys_clk) tick <= 1'b1;
    @(posedge sys_clk) tick <= 1'b0;
    @(posedge sys_clk);
    #1 chk("freq_ref_valid", {15'h0000, ev}, {15'h0000, fvalid});
    if (ev) chk("freq_ref", e, {2'h0, fref});
  endtask : tick_chk

  task automatic mon_chk(input logic [11:0] c1, input logic p1,
                         input logic [11:0] c2, input logic p2);
    repeat (3) @(posedge sys_clk);
    #1 chk("mon_ch1", {3'h0, c1, p1}, {3'h0, mon.ch1_code, mon.ch1_bipolar});
    chk("mon_ch2", {3'h0, c2, p2}, {3'h0, mon.ch2_code, mon.ch2_bipolar});
  endtask : mon_chk

  task automatic t_reset;
    logic [15:0] rv [14] = '{0, 0, 0, 1, 2, 100, 0, 3, 50, 0, 0, 0, 0, 0};
    for (int a = 0; a < 14; a++) xfer(0, 0, 0, a[3:0], rv[a], 16'hffff);
  endtask : t_reset

  task automatic t_locks;
    @(posedge sys_clk) run <= 1'b1;
    xfer(1, A_ANALOG_MODE, 1, A_STATUS, 16'h0003, 16'h0003);
    xfer(0, 0, 0, A_ANALOG_MODE, 16'h0000, 16'hffff);
    xfer(1, A_DIG_FORMAT, 7, A_DIG_FORMAT, 16'h0000, 16'hffff);
    xfer(1, A_STATUS, 1, A_STATUS, 16'h0002, 16'h0003);
    xfer(1, A_MON1_ITEM, 5, A_STATUS, 16'h0001, 16'h0001);
    xfer(0, 0, 0, A_MON1_ITEM, 16'h0002, 16'hffff);
    xfer(1, A_MON1_GAIN, 250, A_MON1_GAIN, 16'h00fa, 16'hffff);
    xfer(1, A_MON1_GAIN, 251, A_MON1_GAIN, 16'h00fa, 16'hffff);
    xfer(1, A_MON1_BIAS, 16'hff9c, A_MON1_BIAS, 16'hff9c, 16'hffff);
    xfer(1, A_MON1_BIAS, 16'hff9b, A_MON1_BIAS, 16'hff9c, 16'hffff);
    @(posedge sys_clk) run <= 1'b0;
    xfer(1, A_STATUS, 1, A_STATUS, 16'h0000, 16'h0003);
    wr(A_MON1_GAIN, 100);
    wr(A_MON1_BIAS, 0);
  endtask : t_locks

  task automatic t_items;
    int bad [14] = '{0, 4, 10, 11, 13, 14, 25, 28, 29, 30, 31, 34, 35, 39};
    foreach (bad[i]) xfer(1, A_MON2_ITEM, bad[i], A_MON2_ITEM, 3, 16'hffff);
    xfer(1, A_MON2_ITEM, 38, A_MON2_ITEM, 38, 16'hffff);
    xfer(1, A_MON2_ITEM, 3, A_MON2_ITEM, 3, 16'hffff);
  endtask : t_items

  task automatic t_digital;
    logic [16:0] w [8] = '{17'h00050, 17'h00123, 17'h10000, 17'h00030,
                           17'h00300, 17'h03000, 17'h00036, 17'h07530};
    logic [15:0] e [8] = '{5000, 1230, 10000, 5000, 5000, 5000, 115, 10000};
    @(posedge sys_clk) begin
      ctype <= CARD_DIG16;
      b16 <= 1'b1;
    end
    wr(A_REF_SOURCE, SRC_OPTION);
    for (int f = 0; f < 8; f++) begin
      wr(A_DIG_FORMAT, f[15:0]);
      tick_chk(1, w[f], e[f]);
    end
    wr(A_DIG_FORMAT, FMT_BCD_SPEC);
    for (int k = 5; k < 8; k++) tick_chk(1, 17'h00030 | k, 115);
    wr(A_DISP_SCALE, 2);
    tick_chk(1, 17'h00036, 60);
    wr(A_DISP_SCALE, 0);
    @(posedge sys_clk) ctype <= CARD_DIG8;
    tick_chk(1, 17'h00036, 0);
    xfer(0, 0, 0, A_STATUS, 16'h0008, 16'h0008);
    wr(A_DIG_FORMAT, FMT_BINARY);
    tick_chk(1, 17'h000ff, 10000);
    @(posedge sys_clk) begin
      ctype <= CARD_DIG16;
      b16 <= 1'b0;
    end
    tick_chk(1, 17'h00fff, 10000);
  endtask : t_digital

  task automatic t_analog;
    @(posedge sys_clk) begin
      ctype <= CARD_AN3;
      ainv <= {14'h0000, 14'h1fff, 14'h0000};
      oin <= 1'b1;
    end
    tick_chk(1, 0, 0);
    wr(A_ANALOG_MODE, 1);
    tick_chk(0, 0, 0);
    wr(A_REF_SOURCE, SRC_TERMINAL);
    tick_chk(1, 0, 10000);
    chk("ch_pct", 16'd10000, {2'h0, chp[1]});
    xfer(0, 0, 0, A_STATUS, 16'h0004, 16'h0004);
    chk("opt_inv_sel_out", 16'h0000, {15'h0000, oout});
  endtask : t_analog

  task automatic t_monitor;
    @(posedge sys_clk) begin
      itemv <= 16'h2710;
      ctype <= CARD_NONE;
    end
    wr(A_OUT_LEVEL, 1);
    mon_chk(12'h0ff, 0, 12'h07f, 0);
    chk("opt_inv_sel_out", 16'h0001, {15'h0000, oout});
    @(posedge sys_clk) m12 <= 1'b1;
    mon_chk(12'hfff, 1, 12'h7ff, 0);
    wr(A_OUT_LEVEL, 0);
    mon_chk(12'hfff, 0, 12'h7ff, 0);
    @(posedge sys_clk) begin
      itemv <= 16'h0000;
      run <= 1'b1;
    end
    wr(A_MON1_BIAS, 100);
    mon_chk(12'h199, 0, 12'h000, 0);
  endtask : t_monitor

  // The whole run needs about 250 cycles; this bound is generous.
  initial begin
    #200us;
    mismatches++;
    stop_test();
  end

  initial begin
    mismatches = 0;
    checks_done = 0;
    rst_n = 1'b0;
    req = '0;
    {run, tick, b16, m12, oin} = '0;
    ctype = CARD_NONE;
    word = '0;
    ainv = '0;
    itemv = '0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset();
    t_locks();
    t_items();
    t_digital();
    t_analog();
    t_monitor();
    stop_test();
  end
endmodule : option_ref_monitor_tb
`default_nettype wire
